// [shared/bcdp_regs.vh]
// Constants of the escape-sequence command parser: bytes, offsets, reset values.
// Assumes inclusion by bare name from design files.
`ifndef BCDP_REGS_VH
`define BCDP_REGS_VH
`define BCDP_ESC        8'h1b
`define BCDP_DASH       8'h2d
`define BCDP_Y          8'h79
`define BCDP_CMD_B      8'h42
`define BCDP_CMD_C      8'h43
`define BCDP_CMD_D      8'h44
`define BCDP_CMD_E      8'h45
`define BCDP_CMD_L      8'h4c
`define BCDP_CMD_M      8'h4d
`define BCDP_CMD_N      8'h4e
`define BCDP_CMD_O      8'h4f
`define BCDP_CMD_S      8'h53
`define BCDP_CMD_T      8'h54
`define BCDP_CMD_U      8'h55
`define BCDP_CMD_W      8'h57
`define BCDP_CMD_X      8'h58
`define BCDP_CR         8'h0d
`define BCDP_ADDR_CFG0  4'h0
`define BCDP_ADDR_CFG1  4'h1
`define BCDP_ADDR_STAT  4'h2
`define BCDP_ADDR_HDR   4'h3
`define BCDP_ADDR_TRL   4'h4
`define BCDP_ADDR_TERM  4'h5
`define BCDP_BEEP_EN_RST   1'b1
`define BCDP_BEEP_TONE_RST 4'hf
`define BCDP_LED_MODE_RST  2'h1
`define BCDP_SCAN_EN_RST   1'b1
`define BCDP_TEXT_MAX   4'ha
`define BCDP_TONE_CYC   24'h0f4240
`endif

// [rtl/bcdp_parser.v]
// Escape-sequence command parser of a bar code decoder: settings, tone, LED, status.
// Assumes bytes arrive as one-cycle strobes on clk; pins come from outside and are synced.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "bcdp_regs.vh"

// What this block does
// - Host configures through escape sequences; the register port also writes the terminator.
// - Every command starts with escape byte 27.
// - Beep enable and tone; reset enabled, 15.
// - Sound tone drives beeper with chosen tone.
// - LED behaviour set; default flash on read.
// - Status request returns current configuration report.
// - Escape E restores pins plus software defaults.
// - Defaults equal all pins high, no commands.
// - Serial-only settings act only in serial mode.
// - Parallel mode forces odd parity.
// - Parallel terminator is CR unless changed.
// - Header and trailer text at most ten.
module bcdp_parser #(
    parameter TONE_CYC = `BCDP_TONE_CYC
) (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        arst_n,
    input  wire        ce,
    // Command byte stream from host
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    // Status report byte stream to host
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    // Hardwired configuration pins
    input  wire        mode_serial_pin,
    input  wire [1:0]  parity_pin,
    // Decoder events and feedback outputs
    input  wire        good_read,
    output reg         beeper,
    output reg         led,
    output reg  [1:0]  parity_eff,
    output reg         scan_en,
    // Register port
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata
);
    // Parser states, one-hot.
    localparam S_IDLE = 5'b00001;
    localparam S_DASH = 5'b00010;
    localparam S_Y    = 5'b00100;
    localparam S_ARG  = 5'b01000;
    localparam S_TEXT = 5'b10000;

    reg [4:0]  st_r;
    reg [7:0]  arg_r;
    reg [7:0]  cmd_r;
    reg [3:0]  tcnt_r;
    reg        mode_m_r, mode_s_r;
    reg [1:0]  par_m_r, par_s_r;
    // Software settings; a hard reset returns each of them to its default, except the text memories hdr_mem and trl_mem.
    reg        beep_en_r;
    reg [3:0]  beep_tone_r;
    reg [1:0]  led_mode_r;
    reg [7:0]  code_sel_r, csum_r, len_r, upc_r;
    reg        pace_r;
    reg [3:0]  hdr_len_r, trl_len_r;
    reg [7:0]  hdr_mem [0:9];
    reg [7:0]  trl_mem [0:9];
    reg [7:0]  term_r;
    reg [3:0]  tone_r;
    reg [23:0] tone_cnt_r;
    reg [15:0] div_r;
    reg [23:0] led_cnt_r;
    reg [1:0]  stat_cnt_r;
    reg        sw_reset;
    reg [7:0]  stat_byte;

    // Final letter accepted: B C D L M N O S T U W X (E handled separately).
    function known;
        input [7:0] c;
        begin
            known = (c == `BCDP_CMD_B) || (c == `BCDP_CMD_C) || (c == `BCDP_CMD_D) ||
                    (c == `BCDP_CMD_L) || (c == `BCDP_CMD_M) || (c == `BCDP_CMD_N) ||
                    (c == `BCDP_CMD_O) || (c == `BCDP_CMD_S) || (c == `BCDP_CMD_T) ||
                    (c == `BCDP_CMD_U) || (c == `BCDP_CMD_W) || (c == `BCDP_CMD_X);
        end
    endfunction

    wire is_digit = (rx_data >= 8'h30) && (rx_data <= 8'h39);
    // Decimal argument accumulates as ten times the old value plus the digit.
    wire [7:0] arg_nxt = (arg_r << 3) + (arg_r << 1) + (rx_data - 8'h30);

    // Pin synchronisers; reset values match pins tied high, the default setup.
    // Only the second stage is read by any logic.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_m_r <= 1'b1;
            mode_s_r <= 1'b1;
            par_m_r  <= 2'h3;
            par_s_r  <= 2'h3;
        end else if (ce) begin
            mode_m_r <= mode_serial_pin;
            mode_s_r <= mode_m_r;
            par_m_r  <= parity_pin;
            par_s_r  <= par_m_r;
        end
    end

    always @* begin
        case (stat_cnt_r)
            2'h3:    stat_byte = {mode_s_r, beep_en_r, led_mode_r, beep_tone_r};
            2'h2:    stat_byte = code_sel_r;
            2'h1:    stat_byte = {pace_r, scan_en, 2'h0, hdr_len_r};
            default: stat_byte = term_r;
        endcase
        sw_reset = rx_valid && (st_r == S_DASH) && (rx_data == `BCDP_CMD_E);
    end

    // Parser and settings.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r        <= S_IDLE;
            arg_r       <= 8'h00;
            cmd_r       <= 8'h00;
            tcnt_r      <= 4'h0;
            beep_en_r   <= `BCDP_BEEP_EN_RST;
            beep_tone_r <= `BCDP_BEEP_TONE_RST;
            led_mode_r  <= `BCDP_LED_MODE_RST;
            code_sel_r  <= 8'h00;
            csum_r      <= 8'h00;
            len_r       <= 8'h00;
            upc_r       <= 8'h00;
            pace_r      <= 1'b0;
            scan_en     <= `BCDP_SCAN_EN_RST;
            hdr_len_r   <= 4'h0;
            trl_len_r   <= 4'h0;
            term_r      <= `BCDP_CR;
            tone_r      <= 4'h0;
            tone_cnt_r  <= 24'h000000;
            stat_cnt_r  <= 2'h0;
            tx_data     <= 8'h00;
            tx_valid    <= 1'b0;
        end else if (ce) begin
            // Status strobe is a one-cycle pulse unless another byte follows.
            tx_valid <= 1'b0;
            if (tone_cnt_r != 24'h000000)
                tone_cnt_r <= tone_cnt_r - 24'h000001;
            // Three status bytes leave back to back, highest count first.
            if (stat_cnt_r != 2'h0) begin
                tx_data  <= stat_byte;
                tx_valid <= 1'b1;
                stat_cnt_r <= stat_cnt_r - 2'h1;
            end
            if (wr && addr == `BCDP_ADDR_TERM)
                term_r <= wdata[7:0];
            // Hard reset wins over a terminator write in the same cycle.
            if (sw_reset) begin
                st_r        <= S_IDLE;
                beep_en_r   <= `BCDP_BEEP_EN_RST;
                beep_tone_r <= `BCDP_BEEP_TONE_RST;
                led_mode_r  <= `BCDP_LED_MODE_RST;
                code_sel_r  <= 8'h00;
                csum_r      <= 8'h00;
                len_r       <= 8'h00;
                upc_r       <= 8'h00;
                pace_r      <= 1'b0;
                scan_en     <= `BCDP_SCAN_EN_RST;
                hdr_len_r   <= 4'h0;
                trl_len_r   <= 4'h0;
                term_r      <= `BCDP_CR;
            end else if (rx_valid) begin
                // Escape restarts a sequence from any state; inside header or trailer text the S_TEXT branch does it.
                if (rx_data == `BCDP_ESC && st_r != S_TEXT) begin
                    st_r <= S_DASH;
                end else begin
                    case (st_r)
                        S_IDLE: st_r <= S_IDLE;
                        S_DASH: st_r <= (rx_data == `BCDP_DASH) ? S_Y : S_IDLE;
                        S_Y: begin
                            arg_r <= 8'h00;
                            st_r  <= (rx_data == `BCDP_Y) ? S_ARG : S_IDLE;
                        end
                        S_ARG: begin
                            if (is_digit) begin
                                arg_r <= arg_nxt;
                            end else if (!known(rx_data)) begin
                                st_r <= S_IDLE;
                            end else begin
                                st_r <= S_IDLE;
                                case (rx_data)
                                    // Argument 0 silences the beep; 1 to 16 pick tones 0 to 15.
                                    `BCDP_CMD_B: begin
                                        beep_en_r   <= (arg_r != 8'h00);
                                        beep_tone_r <= arg_r[3:0] - 4'h1;
                                    end
                                    // A requested tone sounds for TONE_CYC cycles, then stops.
                                    `BCDP_CMD_T: begin
                                        tone_r     <= arg_r[3:0];
                                        tone_cnt_r <= TONE_CYC;
                                    end
                                    `BCDP_CMD_L: led_mode_r <= arg_r[1:0];
                                    `BCDP_CMD_S: stat_cnt_r <= 2'h3;
                                    `BCDP_CMD_C: code_sel_r <= arg_r;
                                    `BCDP_CMD_D: csum_r <= arg_r;
                                    `BCDP_CMD_M: len_r <= arg_r;
                                    `BCDP_CMD_U: upc_r <= arg_r;
                                    `BCDP_CMD_W: scan_en <= arg_r[0];
                                    `BCDP_CMD_X: pace_r <= arg_r[0];
                                    default: begin
                                        cmd_r  <= rx_data;
                                        tcnt_r <= 4'h0;
                                        st_r   <= S_TEXT;
                                    end
                                endcase
                            end
                        end
                        // Text ends at escape or after ten characters; an extra byte is dropped.
                        S_TEXT: begin
                            if (rx_data == `BCDP_ESC || tcnt_r == `BCDP_TEXT_MAX) begin
                                st_r <= (rx_data == `BCDP_ESC) ? S_DASH : S_IDLE;
                            end else begin
                                if (cmd_r == `BCDP_CMD_N)
                                    hdr_len_r <= tcnt_r + 4'h1;
                                else
                                    trl_len_r <= tcnt_r + 4'h1;
                                tcnt_r <= tcnt_r + 4'h1;
                            end
                        end
                        default: st_r <= S_IDLE;
                    endcase
                end
            end
        end
    end

    // Text memories; no reset needed, lengths gate them.
    always @(posedge clk) begin
        if (ce && rx_valid && st_r == S_TEXT && rx_data != `BCDP_ESC &&
            tcnt_r != `BCDP_TEXT_MAX) begin
            if (cmd_r == `BCDP_CMD_N)
                hdr_mem[tcnt_r] <= rx_data;
            else
                trl_mem[tcnt_r] <= rx_data;
        end
    end

    // Beeper: a requested tone wins, else good-read beep; pitch from divider.
    // A higher tone code picks a slower divider bit, so a lower pitch.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r     <= 16'h0000;
            beeper    <= 1'b0;
            led       <= 1'b0;
            led_cnt_r <= 24'h000000;
        end else if (ce) begin
            div_r <= div_r + 16'h0001;
            if (good_read)
                led_cnt_r <= TONE_CYC;
            else if (led_cnt_r != 24'h000000)
                led_cnt_r <= led_cnt_r - 24'h000001;
            if (tone_cnt_r != 24'h000000)
                beeper <= div_r[{1'b0, tone_r[3:1]} + 4'h4];
            else if (beep_en_r && led_cnt_r != 24'h000000)
                beeper <= div_r[{1'b0, beep_tone_r[3:1]} + 4'h4];
            else
                beeper <= 1'b0;
            case (led_mode_r)
                2'h0:    led <= 1'b0;
                2'h1:    led <= (led_cnt_r != 24'h000000);
                2'h2:    led <= 1'b1;
                // Mode 3 blinks while the flash window runs.
                default: led <= ~led_cnt_r[0] & (led_cnt_r != 24'h000000);
            endcase
        end
    end

    // Effective parity and register reads.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            parity_eff <= 2'h2;
            rdata      <= 32'h00000000;
        end else if (ce) begin
            // Parallel mode always reports odd parity; serial follows the synced pins.
            parity_eff <= mode_s_r ? par_s_r : 2'h2;
            // Read data stands only in the cycle after the read strobe.
            rdata      <= 32'h00000000;
            if (rd) begin
                case (addr)
                    `BCDP_ADDR_CFG0: rdata <= {16'h0000, code_sel_r, csum_r};
                    `BCDP_ADDR_CFG1: rdata <= {8'h00, len_r, upc_r, 7'h00, pace_r};
                    `BCDP_ADDR_STAT: rdata <= {24'h000000, mode_s_r, beep_en_r, led_mode_r,
                                               beep_tone_r};
                    `BCDP_ADDR_HDR:  rdata <= {24'h000000, hdr_len_r, trl_len_r};
                    `BCDP_ADDR_TRL:  rdata <= {28'h0000000, st_r[4:1]};
                    `BCDP_ADDR_TERM: rdata <= {24'h000000, term_r};
                    default:         rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// [test/bcdp_checker.sv]
// Checker for the command parser, watching only its ports.
// Assumes one clock domain, clk, with asynchronous active-low arst_n.
`timescale 1ns/1ps
`include "bcdp_regs.vh"
module bcdp_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       ce,
    // Command and status streams
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       tx_valid,
    // Pins and feedback
    input wire logic       mode_serial_pin,
    input wire logic [1:0] parity_pin,
    input wire logic       led,
    input wire logic [1:0] parity_eff,
    input wire logic       scan_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_byte(b);
        ce && rx_valid && rx_data == b;
    endsequence
    sequence s_head;
        s_byte(`BCDP_ESC) ##1 s_byte(`BCDP_DASH) ##1 s_byte(`BCDP_Y);
    endsequence
    property p_status;
        s_head ##1 s_byte(8'h30) ##1 s_byte(`BCDP_CMD_S) |=> ##1 tx_valid[*3] ##1 !tx_valid;
    endproperty
    a_status: assert property (p_status) else $error("status reply not three bytes");
    property p_hard;
        s_byte(`BCDP_ESC) ##1 s_byte(`BCDP_CMD_E) |-> ##[1:2] scan_en;
    endproperty
    a_hard: assert property (p_hard) else $error("scanner not enabled by hard reset");
    property p_scan_off;
        s_head ##1 s_byte(8'h30) ##1 s_byte(`BCDP_CMD_W) |-> ##[1:2] !scan_en;
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("scanner still enabled");
    property p_led_on;
        s_head ##1 s_byte(8'h32) ##1 s_byte(`BCDP_CMD_L) |-> ##3 led[*4];
    endproperty
    a_led_on: assert property (p_led_on) else $error("led not steady on");
    property p_led_off;
        s_head ##1 s_byte(8'h30) ##1 s_byte(`BCDP_CMD_L) |-> ##3 (!led)[*4];
    endproperty
    a_led_off: assert property (p_led_off) else $error("led not off");
    property p_unknown;
        s_head ##1 s_byte(8'h37) ##1 s_byte(8'h5a) |=> (!tx_valid && $stable(scan_en))[*4];
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown letter had an effect");
    property p_par_odd;
        (ce && !mode_serial_pin)[*5] |-> parity_eff == 2'h2;
    endproperty
    a_par_odd: assert property (p_par_odd) else $error("parallel parity not odd");
    property p_par_ser;
        (ce && mode_serial_pin && $stable(parity_pin))[*4] |-> parity_eff == parity_pin;
    endproperty
    a_par_ser: assert property (p_par_ser) else $error("serial parity not from pins");
endmodule
bind bcdp_parser bcdp_checker u_chk (.clk(clk), .arst_n(arst_n), .ce(ce), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_valid(tx_valid), .mode_serial_pin(mode_serial_pin),
    .parity_pin(parity_pin), .led(led), .parity_eff(parity_eff), .scan_en(scan_en));

// [test/bcdp_host_model.sv]
// Host model: sends queued command bytes back to back, one per clock.
// Assumes the bench fills q within one time step.
`timescale 1ns/1ps
module bcdp_host_model (
    // Clock
    input  wire logic       clk,
    // Command byte stream
    output      logic [7:0] rx_data,
    output      logic       rx_valid
);
    logic [7:0] q[$];
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // Idle data flips every cycle so a stale byte never looks valid.
    always @(posedge clk) begin
        if (q.size() != 0) begin
            rx_data  <= q.pop_front();
            rx_valid <= 1'b1;
        end else begin
            rx_data  <= ~rx_data;
            rx_valid <= 1'b0;
        end
    end
endmodule

// [test/test_bcdp_parser.sv]
// Testbench of the command parser: host model, register port, queued checks.
// Assumes TONE_CYC shortened to 100 cycles, long enough for a beeper toggle.
`timescale 1ns/1ps
`include "bcdp_regs.vh"
module test_bcdp_parser;
    // Stimulus
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        msp = 1'b0;
    logic [1:0]  pp = 2'h0;
    logic        good_read = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    // Observed
    wire  [7:0]  rx_data, tx_data;
    wire         rx_valid, tx_valid, beeper, led, scan_en;
    wire  [1:0]  parity_eff;
    wire  [31:0] rdata;
    integer      errors = 0;
    integer      checks_done = 0;
    integer      seed = 32'h8fbc;
    integer      n;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    always #10 clk = ~clk;
    bcdp_host_model host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid));
    bcdp_parser #(.TONE_CYC(24'h000064)) DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .mode_serial_pin(msp), .parity_pin(pp), .good_read(good_read), .beeper(beeper),
        .led(led), .parity_eff(parity_eff), .scan_en(scan_en), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    task chk(input string what, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
        checks_done = checks_done + 1;
        if (((g ^ e) & m) !== 32'h0) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // The oldest note is taken whenever a status byte or read data appears.
    always @(posedge clk) begin
        rd_d <= rd;
        if (tx_valid === 1'b1 || rd_d) begin
            if (exp_q.size() == 0) chk("unexpected result", 32'h0, 32'h1, 32'h1);
            else if (tx_valid === 1'b1) chk("status byte", exp_q.pop_front(), {24'h0, tx_data}, msk_q.pop_front());
            else chk("read data", exp_q.pop_front(), rdata, msk_q.pop_front());
        end
    end
    task note(input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
    endtask
    task go;
        while (host.q.size() != 0) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask
    task cmd(input integer v, input logic [7:0] letter);
        host.q.push_back(`BCDP_ESC);
        host.q.push_back(`BCDP_DASH);
        host.q.push_back(`BCDP_Y);
        if (v > 9) host.q.push_back(8'(48 + v / 10));
        host.q.push_back(8'(48 + v % 10));
        host.q.push_back(letter);
        go;
    endtask
    task status(input logic [7:0] b0, input logic [7:0] m0, input logic [7:0] b2, input logic [7:0] m2);
        note({24'h0, b0}, {24'h0, m0});
        note(32'h0, 32'h0);
        note({24'h0, b2}, {24'h0, m2});
        cmd(0, `BCDP_CMD_S);
    endtask
    task rreg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        note(e, 32'hff);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task see(input string what, input logic sel);
        logic   s0;
        integer k, t;
        s0 = sel ? led : beeper;
        t = 0;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if ((sel ? led : beeper) !== s0) t = 1;
        end
        chk(what, 32'h1, t, 32'h1);
    endtask
    task print_verdict;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #800000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        status(8'h5f, 8'hff, 8'h40, 8'hff);
        rreg(`BCDP_ADDR_TERM, 32'h0d);
        for (n = 0; n < 4; n++) begin
            cmd(n, `BCDP_CMD_L);
            status(8'(n << 4), 8'h30, 8'h0, 8'h0);
        end
        cmd(0, `BCDP_CMD_B);
        status(8'h00, 8'h40, 8'h0, 8'h0);
        repeat (4) begin
            n = 1 + {$random(seed)} % 16;
            cmd(n, `BCDP_CMD_B);
            status(8'h40 | 8'(n - 1), 8'h4f, 8'h0, 8'h0);
        end
        cmd(0, `BCDP_CMD_W);
        cmd(7, 8'h5a);
        status(8'h0, 8'h0, 8'h00, 8'h40);
        $display("test commands done");
        @(posedge clk);
        addr <= `BCDP_ADDR_TERM;
        wdata <= 32'h0a;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rreg(`BCDP_ADDR_TERM, 32'h0a);
        cmd(0, `BCDP_CMD_N);
        repeat (3) host.q.push_back(8'h41);
        go;
        cmd(0, `BCDP_CMD_O);
        repeat (10) host.q.push_back(8'h42);
        go;
        rreg(`BCDP_ADDR_HDR, 32'h3a);
        host.q.push_back(`BCDP_ESC);
        host.q.push_back(`BCDP_CMD_E);
        go;
        status(8'h5f, 8'hff, 8'h40, 8'hff);
        rreg(`BCDP_ADDR_TERM, 32'h0d);
        $display("test hard reset done");
        @(posedge clk);
        good_read <= 1'b1;
        @(posedge clk);
        good_read <= 1'b0;
        see("led flash", 1'b1);
        cmd(1, `BCDP_CMD_T);
        see("beeper", 1'b0);
        msp <= 1'b1;
        pp <= 2'($random(seed));
        repeat (5) @(posedge clk);
        chk("serial parity", {30'h0, pp}, {30'h0, parity_eff}, 32'h3);
        msp <= 1'b0;
        repeat (5) @(posedge clk);
        chk("parallel parity", 32'h2, {30'h0, parity_eff}, 32'h3);
        $display("test feedback and parity done");
        print_verdict;
    end
endmodule
